// ---- verilog/uart_rx_pkg.sv ----
/*
  Constants, register map and shared types of the serial receiver block.
  Assumes a byte-wide register port and one 250 MHz clock.
*/
`default_nettype none
package uart_rx_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // -------------------------------------------------------------------------
  // Register offsets
  // -------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_DATA = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_STATUS_A = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL_B = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL_C = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_BAUD = 3'h4;

  // -------------------------------------------------------------------------
  // Field positions
  // -------------------------------------------------------------------------
  localparam int SA_RX_COMPLETE = 7;
  localparam int SA_FRAME_ERR = 4;
  localparam int SA_OVERRUN = 3;
  localparam int SA_PARITY_ERR = 2;
  localparam int SA_DOUBLE_SPEED = 1;
  localparam int CB_RX_IRQ_EN = 7;
  localparam int CB_RX_EN = 4;
  localparam int CB_TX_EN = 3;
  localparam int CB_SIZE_HI = 2;
  localparam int CB_RX_NINTH = 1;
  localparam int CB_TX_NINTH = 0;
  localparam int CC_SYNC_MODE = 6;
  localparam int CC_PARITY_EN = 5;
  localparam int CC_PARITY_ODD = 4;
  localparam int CC_STOP_SEL = 3;
  localparam int CC_SIZE_LO = 1;

  // -------------------------------------------------------------------------
  // Frame format and sampling
  // -------------------------------------------------------------------------
  localparam logic [2:0] SIZE_RESET = 3'h3;
  localparam logic [2:0] SIZE_NINE = 3'h7;
  localparam logic [3:0] SIZE_BASE = 4'h5;
  localparam logic [3:0] NINE_BITS = 4'h9;
  localparam logic [4:0] OVS_NORMAL = 5'h10;
  localparam logic [4:0] OVS_DOUBLE = 5'h08;
  localparam logic [4:0] VOTE_LAST_NORMAL = 5'h0a;
  localparam logic [4:0] VOTE_LAST_DOUBLE = 5'h06;
  localparam logic [4:0] SAMPLE_FIRST = 5'h01;
  localparam logic [7:0] BAUD_RESET = 8'h00;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b011,
    RX_PARITY = 3'b010,
    RX_STOP = 3'b110
  } rx_state_t;

  typedef struct packed {
    logic [8:0] data;
    logic frame_err;
    logic overrun;
    logic parity_err;
  } rx_frame_t;
endpackage
`default_nettype wire

// ---- verilog/bit_sync.sv ----
/*
  Two-stage synchroniser for a group of asynchronous pin levels.
  Assumes the inputs are slow levels relative to CLK.
*/
`default_nettype none
module bit_sync #(
  parameter int WIDTH = 2
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [WIDTH-1:0] D,
  output logic [WIDTH-1:0] Q
);
  logic [WIDTH-1:0] meta_reg;

  // The first stage feeds the second stage only.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      meta_reg <= '1;
      Q <= '1;
    end else begin
      meta_reg <= D;
      Q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/uart_rx_core.sv ----
/*
  Serial receiver with two-entry receive buffer, its register port, and the
  transmit-disable pin handover. Assumes the transmit data path sits outside
  and reports its shifter and buffer occupancy on the same clock.
*/
`default_nettype none
module uart_rx_core import uart_rx_pkg::*; #(
  parameter int BAUD_W = 8
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [DATA_W-1:0] RDATA,
  input wire logic SERIAL_IN_PIN,
  input wire logic SYNC_TRANSFER_CLOCK_PIN,
  input wire logic TX_SHIFT_BUSY,
  input wire logic TX_BUF_PENDING,
  output logic RX_PIN_OVERRIDE,
  output logic TX_PIN_OVERRIDE,
  output logic TX_NINTH_BIT,
  output logic RX_COMPLETE_IRQ
);
  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------
  logic rx_enable_bit_reg, tx_enable_bit_reg, rx_complete_irq_enable_reg;
  logic double_speed_bit_reg, sync_mode_reg, parity_enable_bit_reg;
  logic parity_odd_even_select_reg, stop_bit_count_select_reg, tx_ninth_bit_reg;
  logic [2:0] char_size_field_reg;
  logic [BAUD_W-1:0] baud_reg;
  logic wr_status, wr_ctrl_b, wr_ctrl_c, rd_data;

  assign wr_status = WR_STB && (ADDR == ADDR_STATUS_A);
  assign wr_ctrl_b = WR_STB && (ADDR == ADDR_CONTROL_B);
  assign wr_ctrl_c = WR_STB && (ADDR == ADDR_CONTROL_C);
  // Only the data location pops; status and control reads are side-effect free.
  assign rd_data = RD_STB && (ADDR == ADDR_DATA);

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rx_enable_bit_reg <= 1'b0;
      tx_enable_bit_reg <= 1'b0;
      rx_complete_irq_enable_reg <= 1'b0;
      tx_ninth_bit_reg <= 1'b0;
      double_speed_bit_reg <= 1'b0;
      sync_mode_reg <= 1'b0;
      parity_enable_bit_reg <= 1'b0;
      parity_odd_even_select_reg <= 1'b0;
      stop_bit_count_select_reg <= 1'b0;
      char_size_field_reg <= SIZE_RESET;
      baud_reg <= BAUD_W'(BAUD_RESET);
    end else begin
      if (wr_status) begin
        // Error flag positions are not writable.
        double_speed_bit_reg <= WDATA[SA_DOUBLE_SPEED];
      end
      if (wr_ctrl_b) begin
        rx_complete_irq_enable_reg <= WDATA[CB_RX_IRQ_EN];
        rx_enable_bit_reg <= WDATA[CB_RX_EN];
        tx_enable_bit_reg <= WDATA[CB_TX_EN];
        char_size_field_reg[2] <= WDATA[CB_SIZE_HI];
        tx_ninth_bit_reg <= WDATA[CB_TX_NINTH];
      end
      if (wr_ctrl_c) begin
        sync_mode_reg <= WDATA[CC_SYNC_MODE];
        parity_enable_bit_reg <= WDATA[CC_PARITY_EN];
        parity_odd_even_select_reg <= WDATA[CC_PARITY_ODD];
        stop_bit_count_select_reg <= WDATA[CC_STOP_SEL];
        char_size_field_reg[1:0] <= WDATA[CC_SIZE_LO+1:CC_SIZE_LO];
      end
      if (WR_STB && (ADDR == ADDR_BAUD)) begin
        baud_reg <= WDATA[BAUD_W-1:0];
      end
    end
  end

  assign TX_NINTH_BIT = tx_ninth_bit_reg;
  // The receive pin belongs to the receiver exactly while it is enabled.
  assign RX_PIN_OVERRIDE = rx_enable_bit_reg;

  // ---------------------------------------------------------------------------
  // Transmitter shutdown
  // ---------------------------------------------------------------------------
  logic tx_active_reg;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      tx_active_reg <= 1'b0;
    end else if (tx_enable_bit_reg) begin
      tx_active_reg <= 1'b1;
    end else if (!TX_SHIFT_BUSY && !TX_BUF_PENDING) begin
      tx_active_reg <= 1'b0;
    end
  end

  // The outside transmitter keeps running while this stays high.
  assign TX_PIN_OVERRIDE = tx_active_reg;

  // ---------------------------------------------------------------------------
  // Pin synchronisation and sample timing
  // ---------------------------------------------------------------------------
  logic [1:0] pins_sync;
  logic rx_in, xck_in, xck_prev_reg, xck_rise, ovs_tick, tick;
  logic [BAUD_W-1:0] baud_cnt_reg;

  bit_sync #(.WIDTH(2)) u_sync (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .D({SYNC_TRANSFER_CLOCK_PIN, SERIAL_IN_PIN}),
    .Q(pins_sync)
  );
  assign rx_in = pins_sync[0];
  assign xck_in = pins_sync[1];

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      // Matches the synchroniser's reset level, so no false edge follows reset.
      xck_prev_reg <= 1'b1;
    end else begin
      xck_prev_reg <= xck_in;
    end
  end
  assign xck_rise = xck_in && !xck_prev_reg;

  always_ff @(posedge CLK) begin
    if (SYS_RST || !rx_enable_bit_reg || baud_cnt_reg == '0) begin
      baud_cnt_reg <= baud_reg;
    end else begin
      baud_cnt_reg <= baud_cnt_reg - 1'b1;
    end
  end
  assign ovs_tick = rx_enable_bit_reg && (baud_cnt_reg == '0);
  // Synchronous mode takes one sample per rising transfer clock edge.
  assign tick = sync_mode_reg ? (xck_rise && rx_enable_bit_reg) : ovs_tick;

  // ---------------------------------------------------------------------------
  // Frame recovery
  // ---------------------------------------------------------------------------
  rx_state_t state_reg;
  logic [4:0] cnt_reg, cur_sample, ovs, vote_last;
  logic [1:0] vote_reg;
  logic [3:0] nbits, bit_idx_reg;
  logic [8:0] shift_reg;
  logic par_acc_reg, par_err_reg, majority, bit_val, at_decide, at_end;
  logic start_det, frame_done;

  assign ovs = double_speed_bit_reg ? OVS_DOUBLE : OVS_NORMAL;
  assign vote_last = double_speed_bit_reg ? VOTE_LAST_DOUBLE : VOTE_LAST_NORMAL;
  assign nbits = (char_size_field_reg == SIZE_NINE) ? NINE_BITS
               : SIZE_BASE + {2'b00, char_size_field_reg[1:0]};
  assign cur_sample = (cnt_reg == ovs) ? SAMPLE_FIRST : cnt_reg + 1'b1;
  // Two of three centre samples decide the bit level.
  assign majority = (vote_reg[1] & vote_reg[0]) | (vote_reg[1] & rx_in)
                  | (vote_reg[0] & rx_in);
  assign bit_val = sync_mode_reg ? rx_in : majority;
  assign at_decide = tick && (sync_mode_reg || cur_sample == vote_last);
  assign at_end = tick && (sync_mode_reg || cur_sample == ovs);
  // Async start needs a high-to-low step between two samples.
  assign start_det = (state_reg == RX_IDLE) && tick && !rx_in
                   && (sync_mode_reg || vote_reg[0]);
  assign frame_done = (state_reg == RX_STOP) && at_decide;

  always_ff @(posedge CLK) begin
    if (SYS_RST || !rx_enable_bit_reg) begin
      vote_reg <= 2'b11;
    end else if (tick) begin
      vote_reg <= {vote_reg[0], rx_in};
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST || !rx_enable_bit_reg) begin
      state_reg <= RX_IDLE;
      cnt_reg <= SAMPLE_FIRST;
      bit_idx_reg <= '0;
    end else begin
      if (tick && state_reg != RX_IDLE) begin
        cnt_reg <= cur_sample;
      end
      case (state_reg)
        RX_IDLE: begin
          if (start_det) begin
            cnt_reg <= SAMPLE_FIRST;
            bit_idx_reg <= '0;
            state_reg <= sync_mode_reg ? RX_DATA : RX_START;
          end
        end
        RX_START: begin
          if (at_decide && majority) begin
            state_reg <= RX_IDLE;
          end else if (at_end) begin
            state_reg <= RX_DATA;
          end
        end
        RX_DATA: begin
          if (at_end) begin
            if (bit_idx_reg == nbits - 1'b1) begin
              state_reg <= parity_enable_bit_reg ? RX_PARITY : RX_STOP;
            end else begin
              bit_idx_reg <= bit_idx_reg + 1'b1;
            end
          end
        end
        RX_PARITY: begin
          if (at_end) begin
            state_reg <= RX_STOP;
          end
        end
        RX_STOP: begin
          // Ends at the first stop bit's vote so further stops are idle time.
          if (at_decide) begin
            state_reg <= RX_IDLE;
          end
        end
        default: begin
          state_reg <= RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST || start_det) begin
      shift_reg <= '0;
      par_acc_reg <= 1'b0;
      par_err_reg <= 1'b0;
    end else if (at_decide && state_reg == RX_DATA) begin
      shift_reg[bit_idx_reg] <= bit_val;
      par_acc_reg <= par_acc_reg ^ bit_val;
    end else if (at_decide && state_reg == RX_PARITY) begin
      // Even parity expects zero over data and parity, odd expects one.
      par_err_reg <= parity_enable_bit_reg
                   && ((par_acc_reg ^ bit_val) != parity_odd_even_select_reg);
    end
  end

  // ---------------------------------------------------------------------------
  // Waiting frame, overrun and receive buffer
  // ---------------------------------------------------------------------------
  localparam int DEPTH = 2;
  rx_frame_t pend_reg, head;
  rx_frame_t fifo_reg [DEPTH];
  logic pend_valid_reg, ovr_reg, wr_ptr_reg, rd_ptr_reg, full, push, pop;
  logic [1:0] count_reg;

  assign full = (count_reg == 2'(DEPTH));
  assign push = pend_valid_reg && !full;
  assign pop = rd_data && (count_reg != '0);
  assign head = fifo_reg[rd_ptr_reg];

  always_ff @(posedge CLK) begin
    if (SYS_RST || !rx_enable_bit_reg) begin
      pend_valid_reg <= 1'b0;
      pend_reg <= '0;
    end else if (frame_done) begin
      pend_valid_reg <= 1'b1;
      pend_reg.data <= shift_reg;
      pend_reg.frame_err <= !bit_val;
      pend_reg.overrun <= 1'b0;
      pend_reg.parity_err <= par_err_reg && parity_enable_bit_reg;
    end else if (push || (start_det && full)) begin
      // A new start with a full buffer drops the waiting frame.
      pend_valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST || !rx_enable_bit_reg) begin
      ovr_reg <= 1'b0;
    end else if (start_det && full && pend_valid_reg) begin
      ovr_reg <= 1'b1;
    end else if (push) begin
      ovr_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST || !rx_enable_bit_reg) begin
      count_reg <= '0;
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
    end else begin
      if (push) begin
        fifo_reg[wr_ptr_reg] <= '{data: pend_reg.data, frame_err: pend_reg.frame_err,
                                  overrun: ovr_reg, parity_err: pend_reg.parity_err};
        wr_ptr_reg <= !wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= !rd_ptr_reg;
      end
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  // Error flags stay out of the request on purpose.
  assign RX_COMPLETE_IRQ = rx_complete_irq_enable_reg && (count_reg != '0);

  // ---------------------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------------------
  logic [DATA_W-1:0] rdata_next, status_a, control_b, control_c;
  logic [8:0] data_mask;
  logic rx_complete_flag;

  assign rx_complete_flag = (count_reg != '0);
  assign data_mask = 9'((10'h001 << nbits) - 10'h001);

  always_comb begin
    status_a = '0;
    status_a[SA_RX_COMPLETE] = rx_complete_flag;
    status_a[SA_FRAME_ERR] = rx_complete_flag && head.frame_err;
    status_a[SA_OVERRUN] = rx_complete_flag && head.overrun;
    status_a[SA_PARITY_ERR] = rx_complete_flag && head.parity_err;
    status_a[SA_DOUBLE_SPEED] = double_speed_bit_reg;
    control_b = '0;
    control_b[CB_RX_IRQ_EN] = rx_complete_irq_enable_reg;
    control_b[CB_RX_EN] = rx_enable_bit_reg;
    control_b[CB_TX_EN] = tx_enable_bit_reg;
    control_b[CB_SIZE_HI] = char_size_field_reg[2];
    control_b[CB_RX_NINTH] = rx_complete_flag && head.data[8];
    control_b[CB_TX_NINTH] = tx_ninth_bit_reg;
    control_c = '0;
    control_c[CC_SYNC_MODE] = sync_mode_reg;
    control_c[CC_PARITY_EN] = parity_enable_bit_reg;
    control_c[CC_PARITY_ODD] = parity_odd_even_select_reg;
    control_c[CC_STOP_SEL] = stop_bit_count_select_reg;
    control_c[CC_SIZE_LO+1:CC_SIZE_LO] = char_size_field_reg[1:0];
    if (ADDR == ADDR_DATA) begin
      rdata_next = rx_complete_flag ? (head.data[7:0] & data_mask[7:0]) : '0;
    end else if (ADDR == ADDR_STATUS_A) begin
      rdata_next = status_a;
    end else if (ADDR == ADDR_CONTROL_B) begin
      rdata_next = control_b;
    end else if (ADDR == ADDR_CONTROL_C) begin
      rdata_next = control_c;
    end else if (ADDR == ADDR_BAUD) begin
      rdata_next = DATA_W'(baud_reg);
    end else begin
      rdata_next = '0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      RDATA <= '0;
    end else if (RD_STB) begin
      RDATA <= rdata_next;
    end else begin
      RDATA <= '0;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  tx_drain_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    tx_active_reg && (TX_SHIFT_BUSY || TX_BUF_PENDING) |=> TX_PIN_OVERRIDE)
    else $error("transmitter stopped with data pending");
  tx_release_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    !tx_enable_bit_reg && !TX_SHIFT_BUSY && !TX_BUF_PENDING |=> !TX_PIN_OVERRIDE)
    else $error("transmit pin not released");
  rx_pin_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    wr_ctrl_b |=> RX_PIN_OVERRIDE == $past(WDATA[CB_RX_EN]))
    else $error("receive pin ownership wrong");
  rx_flush_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    wr_ctrl_b && !WDATA[CB_RX_EN] |=> ##1 !rx_complete_flag && state_reg == RX_IDLE)
    else $error("buffer not flushed on disable");
  fifo_pop_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    pop && !push |=> count_reg == $past(count_reg) - 2'h1)
    else $error("data read did not advance buffer");
  status_read_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    RD_STB && ADDR != ADDR_DATA && !push && rx_enable_bit_reg |=> $stable(count_reg))
    else $error("non-data read changed buffer");
  irq_level_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    RX_COMPLETE_IRQ && !pop |=> RX_COMPLETE_IRQ || !rx_complete_irq_enable_reg
      || !rx_enable_bit_reg)
    else $error("receive request dropped without read");
  status_write_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    wr_status && !pop && count_reg != '0 && rx_enable_bit_reg |=> $stable(head))
    else $error("status write altered flags");
  overrun_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    start_det && full && pend_valid_reg && rx_enable_bit_reg |=> ovr_reg)
    else $error("overrun not flagged");
  mask_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    rd_data && nbits < 4'h8 |=> RDATA[7] == 1'b0)
    else $error("upper data bits not masked");
  parity_off_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    frame_done && !parity_enable_bit_reg |=> !pend_reg.parity_err)
    else $error("parity error with checking off");
endmodule
`default_nettype wire

// ---- verif/serial_tx_model.sv ----
/* Behavioural far-end serial transmitter driving the receive pin.
   Assumes the bench builds the frame bits, start bit first. */
`default_nettype none
module serial_tx_model (
  input wire logic CLK,
  input wire logic GO,
  input wire logic [11:0] BITS,
  input wire logic [3:0] NBITS,
  input wire logic [4:0] BIT_CYC,
  output var logic LINE,
  output var logic BUSY,
  output var logic SCK
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    LINE = 1'b1;
    BUSY = 1'b0;
    SCK = 1'b0;
  end
  // Between frames the line rests high and the transfer clock rests low.
  // The transfer clock rises in mid-bit, where the line level is settled.
  always @(posedge CLK) begin
    if (GO) begin
      BUSY <= 1'b1;
      for (int i = 0; i < NBITS; i++) begin
        LINE <= BITS[i];
        SCK <= 1'b0;
        repeat (BIT_CYC / 2) @(posedge CLK);
        SCK <= 1'b1;
        repeat (BIT_CYC - BIT_CYC / 2) @(posedge CLK);
      end
      LINE <= 1'b1;
      SCK <= 1'b0;
      BUSY <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- verif/tb_uart_rx_core.sv ----
/* Self-checking bench for the serial receiver core.
   Assumes the model on the receive pin and a baud divider of zero, or of one with double speed. */
`default_nettype none
module tb_uart_rx_core import uart_rx_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, go = 1'b0, glitch = 1'b0;
  logic tx_busy = 1'b0, tx_pend = 1'b0;
  logic [ADDR_W-1:0] addr = 3'h0;
  logic [DATA_W-1:0] wdata = 8'h00, rdata;
  logic [11:0] bits = 12'h000;
  logic [3:0] nb = 4'h0;
  logic [4:0] bcyc = 5'h10;
  wire logic line, busy, rx_ovr, tx_ovr, tx9, irq, sync_transfer_clock_pin;
  int failures = 0, n_tests = 0;
  typedef struct packed {
    logic [7:0] cc; logic dbl; logic [8:0] d; logic pb; logic sp; logic [7:0] ed, es;
  } row_t;
  row_t rows [6] = '{
    '{8'h06, 1'b0, 9'h0a5, 1'b0, 1'b1, 8'ha5, 8'h80},
    '{8'h00, 1'b0, 9'h01f, 1'b0, 1'b1, 8'h1f, 8'h80},
    '{8'h26, 1'b0, 9'h03c, 1'b0, 1'b1, 8'h3c, 8'h80},
    '{8'h26, 1'b0, 9'h03c, 1'b1, 1'b1, 8'h3c, 8'h84},
    '{8'h36, 1'b1, 9'h001, 1'b0, 1'b1, 8'h01, 8'h82},
    '{8'h0c, 1'b0, 9'h055, 1'b0, 1'b0, 8'h55, 8'h90}};
  uart_rx_core #(.BAUD_W(8)) uut (.CLK(clk), .SYS_RST(rst), .ADDR(addr), .WDATA(wdata),
    .WR_STB(wr), .RD_STB(rd), .RDATA(rdata), .SERIAL_IN_PIN(line & ~glitch),
    .SYNC_TRANSFER_CLOCK_PIN(sync_transfer_clock_pin), .TX_SHIFT_BUSY(tx_busy), .TX_BUF_PENDING(tx_pend),
    .RX_PIN_OVERRIDE(rx_ovr), .TX_PIN_OVERRIDE(tx_ovr), .TX_NINTH_BIT(tx9),
    .RX_COMPLETE_IRQ(irq));
  serial_tx_model tx (.CLK(clk), .GO(go), .BITS(bits), .NBITS(nb), .BIT_CYC(bcyc),
    .LINE(line), .BUSY(busy), .SCK(sync_transfer_clock_pin));
  initial forever #2 clk = ~clk;
  task automatic results();
    $display("compares %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wrr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // Parity is worked out here so a row can ask for a deliberately wrong bit.
  task automatic send(input logic [8:0] d, input int n, input logic [7:0] cc,
                      input logic pb, input logic sp);
    logic [11:0] b;
    int k;
    b = 12'h000;
    k = 1;
    for (int i = 0; i < n; i++) begin
      b[k] = d[i];
      k++;
    end
    if (cc[CC_PARITY_EN]) begin
      b[k] = ^(d & ((9'h1 << n) - 9'h1)) ^ cc[CC_PARITY_ODD] ^ pb;
      k++;
    end
    b[k] = sp;
    @(posedge clk);
    bits <= b;
    nb <= 4'(k + 1);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    while (busy !== 1'b0) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask
  initial begin
    #60000;
    failures++;
    results();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdc(ADDR_CONTROL_B, 8'h00);
    rdc(ADDR_CONTROL_C, {5'h00, SIZE_RESET[1:0], 1'b0});
    rdc(ADDR_STATUS_A, 8'h00);
    rdc(3'h5, 8'h00);
    chk({6'h00, rx_ovr, tx_ovr}, 8'h00);
    wrr(ADDR_BAUD, 8'h00);
    wrr(ADDR_CONTROL_B, 8'h90);
    #1 chk({7'h00, rx_ovr}, 8'h01);
    $display("reset test done");
    foreach (rows[i]) begin
      wrr(ADDR_STATUS_A, {6'h00, rows[i].dbl, 1'b0});
      wrr(ADDR_CONTROL_C, rows[i].cc);
      bcyc <= rows[i].dbl ? OVS_DOUBLE : OVS_NORMAL;
      send(rows[i].d, 5 + rows[i].cc[2:1], rows[i].cc, rows[i].pb, rows[i].sp);
      rdc(ADDR_STATUS_A, rows[i].es);
      rdc(ADDR_DATA, rows[i].ed);
      $display("row %0d done", i);
    end
    wrr(ADDR_STATUS_A, 8'h00);
    wrr(ADDR_CONTROL_C, 8'h06);
    bcyc <= OVS_NORMAL;
    send(9'h011, 8, 8'h06, 1'b0, 1'b1);
    send(9'h022, 8, 8'h06, 1'b0, 1'b1);
    #1 chk({7'h00, irq}, 8'h01);
    rdc(ADDR_STATUS_A, 8'h80);
    rdc(ADDR_CONTROL_B, 8'h90);
    rdc(ADDR_DATA, 8'h11);
    rdc(ADDR_DATA, 8'h22);
    chk({7'h00, irq}, 8'h00);
    for (int i = 1; i < 5; i++) send(9'h030 + 9'(i), 8, 8'h06, 1'b0, 1'b1);
    rdc(ADDR_DATA, 8'h31);
    rdc(ADDR_STATUS_A, 8'h80);
    rdc(ADDR_DATA, 8'h32);
    rdc(ADDR_STATUS_A, 8'h88);
    rdc(ADDR_DATA, 8'h34);
    send(9'h035, 8, 8'h06, 1'b0, 1'b1);
    rdc(ADDR_STATUS_A, 8'h80);
    rdc(ADDR_DATA, 8'h35);
    $display("fifo and overrun test done");
    wrr(ADDR_CONTROL_B, 8'h10);
    send(9'h040, 8, 8'h06, 1'b0, 1'b0);
    #1 chk({7'h00, irq}, 8'h00);
    wrr(ADDR_STATUS_A, 8'h00);
    rdc(ADDR_STATUS_A, 8'h90);
    rdc(ADDR_DATA, 8'h40);
    @(posedge clk);
    glitch <= 1'b1;
    repeat (3) @(posedge clk);
    glitch <= 1'b0;
    repeat (300) @(posedge clk);
    rdc(ADDR_STATUS_A, 8'h00);
    wrr(ADDR_CONTROL_C, 8'h46);
    send(9'h0a5, 8, 8'h46, 1'b0, 1'b1);
    rdc(ADDR_STATUS_A, 8'h80);
    rdc(ADDR_DATA, 8'ha5);
    wrr(ADDR_CONTROL_C, 8'h06);
    wrr(ADDR_STATUS_A, 8'h02);
    wrr(ADDR_BAUD, 8'h01);
    send(9'h0c3, 8, 8'h06, 1'b0, 1'b1);
    rdc(ADDR_BAUD, 8'h01);
    rdc(ADDR_STATUS_A, 8'h82);
    rdc(ADDR_DATA, 8'hc3);
    wrr(ADDR_BAUD, 8'h00);
    wrr(ADDR_STATUS_A, 8'h00);
    $display("sync and divider tests done");
    wrr(ADDR_CONTROL_B, 8'h94);
    send(9'h15a, 9, 8'h06, 1'b0, 1'b1);
    rdc(ADDR_CONTROL_B, 8'h96);
    rdc(ADDR_DATA, 8'h5a);
    send(9'h066, 9, 8'h06, 1'b0, 1'b1);
    wrr(ADDR_CONTROL_B, 8'h00);
    #1 chk({6'h00, irq, rx_ovr}, 8'h00);
    rdc(ADDR_STATUS_A, 8'h00);
    $display("error, nine-bit and flush tests done");
    @(posedge clk);
    tx_busy <= 1'b1;
    wrr(ADDR_CONTROL_B, 8'h09);
    @(posedge clk);
    #1 chk({6'h00, tx_ovr, tx9}, 8'h03);
    @(posedge clk);
    tx_pend <= 1'b1;
    wrr(ADDR_CONTROL_B, 8'h00);
    tx_busy <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk({7'h00, tx_ovr}, 8'h01);
    @(posedge clk);
    tx_pend <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk({7'h00, tx_ovr}, 8'h00);
    $display("tx shutdown test done");
    results();
  end
endmodule
`default_nettype wire
